//--- verilog/rps_params.svh
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH
`define RPS_AW              16
`define RPS_DW              16
`define RPS_SP_RESET        16'h0000
`define RPS_PC_RESET        16'h0000
`define RPS_GLOBAL_INTERRUPT_MASK_RESET      1'b1
`define RPS_OP_STD          2'h0
`define RPS_OP_DLY          2'h1
`define RPS_OP_STD_UM       2'h2
`define RPS_OP_DLY_UM       2'h3
`define RPS_STD_CYCLES      5
`define RPS_DLY_CYCLES      3
`define RPS_FLUSH_SLOTS     2
`define RPS_SLOT_CYC        4'h6
`define RPS_DONE_CYC        4'hB
`endif

//--- verilog/rps_pkg.sv
package rps_pkg;
   typedef enum logic [2:0] {
      RPS_IDLE   = 3'b000,
      RPS_FETCH  = 3'b001,
      RPS_DECODE = 3'b011,
      RPS_ACCESS = 3'b010,
      RPS_READ   = 3'b110,
      RPS_EXEC   = 3'b111,
      RPS_TAIL   = 3'b101
   } rps_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic        valid;
   } rps_bus_req_t;

   typedef struct packed {
      logic [1:0] kind;
      logic       delayed;
      logic       unmask;
   } rps_op_t;
endpackage

//--- verilog/rps_slot_tracker.sv
`timescale 1ns/100ps
`include "rps_params.svh"
module rps_slot_tracker
   import rps_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_resetn,
   input  wire logic i_start,
   input  wire logic i_delayed,
   output logic      o_charge,
   output logic      o_dummy,
   output logic      o_follower_ok
);
   // ****************************************
   // execute-slot accounting after execute stage
   // ****************************************
   logic [2:0] cnt_r;
   logic       dly_r;
   logic [2:0] cnt_nxt;
   wire        running = (cnt_r != 3'h0);

   assign cnt_nxt = i_start ? 3'h1 :
                    (running && cnt_r != 3'h5) ? cnt_r + 3'h1 : 3'h0;

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         cnt_r <= 3'h0;
         dly_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         if (i_start) begin
            dly_r <= i_delayed;
         end
      end
   end

   // slots 1,2 after execute belong to followers; 3,4 are dummies
   assign o_charge      = (cnt_r == 3'h1 || cnt_r == 3'h2) && !dly_r;
   assign o_follower_ok = (cnt_r == 3'h1 || cnt_r == 3'h2) && dly_r;
   assign o_dummy       = (cnt_r == 3'h3 || cnt_r == 3'h4);
endmodule

//--- verilog/rps_return_seq.sv
// Operation
// - standard exit costs five execute cycles though one word long
// - cycle 1 program address bus holds the exit instruction address
// - cycle 2 exit opcode arrives on program read bus
// - cycles 3,4 fetch two followers; standard exit flushes them
// - cycle 4 stack pointer increments and drives data read address
// - cycle 5 return address captured from data read bus
// - cycle 6 return address placed on program address bus
// - standard exit charged cycles 7 and 8 for flushed followers
// - no prefetch in cycles 4,5 and no fetch in 5,6; dummies in 9,10
// - target instruction completes execution in cycle 11
// - delayed exit same timing; followers execute; costs three cycles
// - unmasking variants time like standard and delayed exits
// - unmasking variants clear global interrupt mask in execute
`timescale 1ns/100ps
`include "rps_params.svh"
module rps_return_seq
   import rps_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_start,
   input  wire logic [1:0]  i_op_kind,
   input  wire logic [15:0] i_exit_addr,
   input  wire logic [15:0] i_fall_addr,
   input  wire logic [15:0] i_program_read_bus,
   input  wire logic [15:0] i_data_read_bus,
   output logic             o_busy,
   output logic [15:0]      o_program_address_bus,
   output logic             o_prefetch_en,
   output logic             o_fetch_en,
   output logic [15:0]      o_data_read_address_bus,
   output logic             o_data_read_en,
   output logic [15:0]      o_stack_pointer,
   output logic [15:0]      o_instruction_register,
   output logic             o_flush,
   output logic             o_follower_exec,
   output logic             o_exec_charge,
   output logic             o_dummy_cycle,
   output logic             o_target_done,
   output logic             o_global_interrupt_mask
);
   // ****************************************
   // decode helpers
   // ****************************************
   function automatic rps_op_t rps_decode(input logic [1:0] k);
      rps_op_t d;
      d.kind    = k;
      d.delayed = (k == `RPS_OP_DLY) || (k == `RPS_OP_DLY_UM);
      d.unmask  = (k == `RPS_OP_STD_UM) || (k == `RPS_OP_DLY_UM);
      return d;
   endfunction

   // ****************************************
   // state
   // ****************************************
   rps_state_t   state_r;
   rps_state_t   state_nxt;
   rps_op_t      op_r;
   logic [15:0]  sp_r;
   logic [15:0]  ret_r;
   logic [15:0]  pab_r;
   logic [15:0]  pc_r;
   logic [15:0]  ir_r;
   logic [15:0]  dab_r;
   logic         global_interrupt_mask_r;
   logic         pf_r;
   logic         f_r;
   logic         dre_r;
   logic         flush_r;
   logic [3:0]   cyc_r;
   logic         charge_w;
   logic         dummy_w;
   logic         fok_w;
   wire rps_op_t op_in = rps_decode(i_op_kind);
   wire          take     = i_start && (state_r == RPS_IDLE);
   wire          go_ex    = (state_r == RPS_READ);
   // slot accounting starts as the target is fetched, so the charge
   // lands on the two slots right after the exit's own execute slot
   wire          slot_go  = (state_r == RPS_TAIL) &&
                            (cyc_r == `RPS_SLOT_CYC);
   wire          last_cyc = (state_r == RPS_TAIL) &&
                            (cyc_r == `RPS_DONE_CYC);

   // every stage takes one cycle but RPS_TAIL, which takes six; the walk is fixed, so the sequence
   // cannot be stalled and callers must hold off during o_busy
   always_comb begin
      case (state_r)
         RPS_IDLE:   state_nxt = take ? RPS_FETCH : RPS_IDLE;
         RPS_FETCH:  state_nxt = RPS_DECODE;
         RPS_DECODE: state_nxt = RPS_ACCESS;
         RPS_ACCESS: state_nxt = RPS_READ;
         RPS_READ:   state_nxt = RPS_EXEC;
         RPS_EXEC:   state_nxt = RPS_TAIL;
         RPS_TAIL:   state_nxt = last_cyc ? RPS_IDLE : RPS_TAIL;
         default:    state_nxt = RPS_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_r <= RPS_IDLE;
         cyc_r   <= 4'h0;
      end else begin
         state_r <= state_nxt;
         cyc_r   <= take ? 4'h1 :
                    (state_nxt == RPS_IDLE) ? 4'h0 : cyc_r + 4'h1;
      end
   end

   // ****************************************
   // bus and stack datapath
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         op_r    <= '0;
         sp_r    <= `RPS_SP_RESET;
         ret_r   <= 16'h0000;
         pab_r   <= `RPS_PC_RESET;
         pc_r    <= `RPS_PC_RESET;
         ir_r    <= 16'h0000;
         dab_r   <= 16'h0000;
         global_interrupt_mask_r  <= `RPS_GLOBAL_INTERRUPT_MASK_RESET;
         pf_r    <= 1'b0;
         f_r     <= 1'b0;
         dre_r   <= 1'b0;
         flush_r <= 1'b0;
      end else begin
         pf_r    <= 1'b0;
         f_r     <= 1'b0;
         dre_r   <= 1'b0;
         flush_r <= 1'b0;
         if (take) begin
            op_r  <= op_in;
            pab_r <= i_exit_addr;
            pc_r  <= i_fall_addr;
            pf_r  <= 1'b1;
         end
         case (state_r)
            RPS_FETCH: begin
               f_r   <= 1'b1;
               pab_r <= pc_r;
               pf_r  <= 1'b1;
            end
            RPS_DECODE: begin
               // opcode stands on the read bus one cycle after its prefetch
               ir_r    <= i_program_read_bus;
               f_r     <= 1'b1;
               pab_r   <= pc_r + 16'h0001;
               pf_r    <= 1'b1;
            end
            RPS_ACCESS: begin
               f_r     <= 1'b1;
               flush_r <= !op_r.delayed;
               sp_r    <= sp_r + 16'h0001;
               dab_r   <= sp_r + 16'h0001;
               dre_r   <= 1'b1;
            end
            RPS_READ: begin
               flush_r <= !op_r.delayed;
            end
            RPS_EXEC: begin
               // the stack word goes straight to the bus; waiting for a
               // register copy would cost one more empty slot
               ret_r <= i_data_read_bus;
               pab_r <= i_data_read_bus;
               pf_r  <= 1'b1;
               if (op_r.unmask) begin
                  global_interrupt_mask_r <= 1'b0;
               end
            end
            RPS_TAIL: begin
               if (slot_go) begin
                  f_r <= 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // slot accounting
   // ****************************************
   rps_slot_tracker u_slots (
      .i_clk         (i_clk),
      .i_resetn      (i_resetn),
      .i_start       (slot_go),
      .i_delayed     (op_r.delayed),
      .o_charge      (charge_w),
      .o_dummy       (dummy_w),
      .o_follower_ok (fok_w)
   );

   // prefetch pulses fall at cycles 1..3 and 6; cycles 4,5 stay empty
   assign o_busy                  = (state_r != RPS_IDLE);
   assign o_program_address_bus   = pab_r;
   assign o_prefetch_en           = pf_r;
   assign o_fetch_en              = f_r;
   assign o_data_read_address_bus = dab_r;
   assign o_data_read_en          = dre_r;
   assign o_stack_pointer         = sp_r;
   assign o_instruction_register  = ir_r;
   assign o_flush                 = flush_r;
   assign o_follower_exec         = fok_w;
   assign o_exec_charge           = charge_w;
   assign o_dummy_cycle           = dummy_w;
   assign o_target_done           = last_cyc;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   // reset aborts any exit in flight, so no check spans a reset
   default disable iff (!i_resetn);

   sequence s_fetch_phase;
      take ##1 o_prefetch_en ##1 o_fetch_en;
   endsequence

   sequence s_stack_phase;
      o_data_read_en ##1 1'b1 ##1 o_prefetch_en;
   endsequence

   exit_addr_a: assert property (take |=> o_program_address_bus ==
      $past(i_exit_addr)) else $error("exit address not on bus");
   opcode_fetch_a: assert property (take |-> ##2 o_fetch_en)
      else $error("opcode fetch missing");
   stack_read_a: assert property (s_fetch_phase |-> ##2 s_stack_phase)
      else $error("stack read out of place");
   sp_step_a: assert property (o_data_read_en |->
      o_data_read_address_bus == o_stack_pointer)
      else $error("read address differs from stack pointer");
   ret_load_a: assert property (go_ex |=> ##1
      o_program_address_bus == $past(i_data_read_bus))
      else $error("return address not driven");
   no_prefetch_a: assert property (take |-> ##4 !o_prefetch_en [*2])
      else $error("prefetch during stack cycles");
   dummy_two_a: assert property (take |-> ##9 o_dummy_cycle [*2])
      else $error("dummy slots misplaced");
   target_done_a: assert property (take |-> ##11 o_target_done)
      else $error("target not complete in cycle 11");
   flush_std_a: assert property (take && !op_in.delayed |->
      ##4 o_flush [*2]) else $error("followers not flushed");
   charge_a: assert property (take && !op_in.delayed |->
      ##7 o_exec_charge [*2]) else $error("exit slots not charged");
   delayed_a: assert property (take && op_in.delayed |->
      ##7 (o_follower_exec && !o_exec_charge) [*2])
      else $error("delayed followers not executed");
   unmask_a: assert property (take && op_in.unmask |->
      ##6 !o_global_interrupt_mask) else $error("mask not cleared");
   length_a: assert property (take |-> ##1 o_busy [*8])
      else $error("sequence ended early");
   busy_span_a: assert property (take |-> ##11 o_busy ##1 !o_busy)
      else $error("busy span not eleven cycles");

   // ****************************************
   // checks: fetch side
   // ****************************************
   opcode_load_a: assert property (take |-> ##3
      o_instruction_register == $past(i_program_read_bus))
      else $error("opcode not held in instruction register");
   follow_fetch_a: assert property (take |-> ##3 o_fetch_en [*2])
      else $error("follower fetch missing");
   no_fetch_a: assert property (take |-> ##5 !o_fetch_en [*2])
      else $error("fetch during empty slots");
   ret_slot_a: assert property (take |-> ##6 o_prefetch_en)
      else $error("target prefetch misplaced");

   // ****************************************
   // checks: stack side
   // ****************************************
   read_slot_a: assert property (take |-> ##4 o_data_read_en)
      else $error("stack read not in cycle four");
   sp_inc_a: assert property (o_data_read_en |->
      o_stack_pointer == $past(o_stack_pointer) + 16'h0001)
      else $error("stack pointer not stepped");
   ret_hold_a: assert property (go_ex |=> ##1
      o_program_address_bus == ret_r)
      else $error("return word and bus differ");

   // ****************************************
   // checks: slots and mask
   // ****************************************
   no_flush_dly_a: assert property (take && op_in.delayed |->
      ##4 !o_flush [*2]) else $error("delayed followers flushed");
   dummy_only_a: assert property (o_dummy_cycle |->
      !o_exec_charge && !o_follower_exec)
      else $error("dummy slot also charged");
   done_end_a: assert property (o_target_done |=> !o_busy)
      else $error("busy after target done");
   mask_edge_a: assert property (take && op_in.unmask &&
      o_global_interrupt_mask |-> ##5 o_global_interrupt_mask ##1
      !o_global_interrupt_mask) else $error("mask cleared off execute");
   mask_keep_a: assert property (take && !op_in.unmask &&
      o_global_interrupt_mask |-> ##11 o_global_interrupt_mask)
      else $error("plain exit touched mask");

   assign o_global_interrupt_mask = global_interrupt_mask_r;
endmodule

//--- tb/rps_mem_model.sv
`timescale 1ns/100ps
// ***************************************************
// program and data memory seen from the sequencer
// ***************************************************
module rps_mem_model (
   input  wire logic        i_clk,
   input  wire logic        i_prefetch_en,
   input  wire logic        i_fetch_en,
   input  wire logic        i_data_read_en,
   input  wire logic [15:0] i_pab,
   input  wire logic [15:0] i_dab,
   output logic [15:0]      o_prog,
   output logic [15:0]      o_data
);
   logic [15:0] paddr_r = 16'h0000;
   logic [15:0] daddr_r = 16'h0000;
   logic [15:0] plast_r = 16'h0000;
   logic [15:0] dlast_r = 16'h0000;
   logic        pval_r  = 1'b0;
   logic        dval_r  = 1'b0;
   wire         pvalid  = i_fetch_en | pval_r;
   wire         dvalid  = i_data_read_en | dval_r;
   wire  [15:0] daddr   = i_data_read_en ? i_dab : daddr_r;
   // released buses toggle so a stale word can never pass as fresh
   assign o_prog = pvalid ? (paddr_r ^ 16'h5A5A) : ~plast_r;
   assign o_data = dvalid ? ~daddr : ~dlast_r;
   always @(posedge i_clk) begin
      if (i_prefetch_en)
         paddr_r <= i_pab;
      if (i_data_read_en)
         daddr_r <= i_dab;
      pval_r  <= i_prefetch_en;
      dval_r  <= i_data_read_en;
      plast_r <= o_prog;
      dlast_r <= o_data;
   end
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
   import rps_pkg::*;
   typedef struct {
      logic [1:0] kind;
      logic [15:0] ea;
      int chg;
      int fol;
      logic mask;
      logic poke;
   } rps_row_t;
   logic i_clk = 0, i_resetn = 0, i_start = 0;
   logic [1:0] i_op_kind = 2'h0;
   logic [15:0] i_exit_addr = 16'h0000, i_fall_addr = 16'h0000;
   logic [15:0] prog, data, program_address_bus, dab, sp, ir;
   logic busy, pf_en, f_en, dr_en, flush, fol_ex, chg, dum, done, mask;
   int num_errors = 0, cmp_count = 0;
   logic [15:0] sp_exp = 16'h0000;
   rps_row_t rows [4];
   rps_return_seq uut (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_start(i_start), .i_op_kind(i_op_kind), .i_exit_addr(i_exit_addr),
      .i_fall_addr(i_fall_addr), .i_program_read_bus(prog),
      .i_data_read_bus(data), .o_busy(busy), .o_program_address_bus(program_address_bus),
      .o_prefetch_en(pf_en), .o_fetch_en(f_en),
      .o_data_read_address_bus(dab), .o_data_read_en(dr_en),
      .o_stack_pointer(sp), .o_instruction_register(ir), .o_flush(flush),
      .o_follower_exec(fol_ex), .o_exec_charge(chg), .o_dummy_cycle(dum),
      .o_target_done(done), .o_global_interrupt_mask(mask));
   rps_mem_model mem (.i_clk(i_clk), .i_prefetch_en(pf_en),
      .i_fetch_en(f_en), .i_data_read_en(dr_en), .i_pab(program_address_bus), .i_dab(dab),
      .o_prog(prog), .o_data(data));
   initial begin
      forever #50 i_clk = ~i_clk;
   end
   task check(input string nm, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task end_sim;
      if (num_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // poke retries a start while busy; it must be ignored
   task run(input logic [1:0] k, input logic [15:0] ea, input int ec, ef,
            input logic poke);
      int n, pf, fl, ch, fo, du, du_at, td_at, dr_at, fe;
      logic seen_dr, got_ret;
      {pf, fl, ch, fo, du, du_at, td_at, dr_at, fe} = '0;
      {seen_dr, got_ret} = 2'b00;
      @(negedge i_clk);
      i_start = 1;
      i_op_kind = k;
      i_exit_addr = ea;
      i_fall_addr = ea + 16'h0001;
      for (n = 1; n <= 14; n++) begin
         @(negedge i_clk);
         i_start = poke && n == 5;
         if (pf_en === 1'b1) begin
            if (pf == 0)
               check("first_pab", program_address_bus, ea);
            if (seen_dr && !got_ret) begin
               got_ret = 1;
               check("ret_pab", program_address_bus, ~(sp_exp + 16'h0001));
            end
            pf++;
         end
         if (dr_en === 1'b1) begin
            dr_at = n;
            seen_dr = 1;
            check("read_addr", dab, sp_exp + 16'h0001);
         end
         if (flush === 1'b1) fl++;
         if (f_en === 1'b1) fe++;
         if (chg === 1'b1) ch++;
         if (fol_ex === 1'b1) fo++;
         if (dum === 1'b1) begin
            if (du == 0) du_at = n;
            du++;
         end
         if (done === 1'b1) td_at = n;
      end
      sp_exp = sp_exp + 16'h0001;
      check("stack_ptr", sp, sp_exp);
      check("read_at", 16'(dr_at), 16'h0004);
      check("ret_seen", 16'(got_ret), 16'h0001);
      check("prefetches", 16'(pf), 16'h0004);
      check("fetches", 16'(fe), 16'h0004);
      check("opcode", ir, ea ^ 16'h5A5A);
      check("flush", 16'(fl), 16'(ec));
      check("charge", 16'(ch), 16'(ec));
      check("follow", 16'(fo), 16'(ef));
      check("dummies", 16'(du), 16'h0002);
      check("dummy_at", 16'(du_at), 16'h0009);
      check("done_at", 16'(td_at), 16'h000B);
      check("busy", 16'(busy), 16'h0000);
   endtask
   task check_reset;
      check("busy_rst", 16'(busy), 16'h0000);
      check("mask_rst", 16'(mask), 16'h0001);
      check("sp_rst", sp, 16'h0000);
      check("pab_rst", program_address_bus, 16'h0000);
   endtask
   initial begin
      #(100 * 2000);
      num_errors++;
      end_sim;
   end
   initial begin
      rows[0] = '{2'h0, 16'h1234, 2, 0, 1'b1, 1'b0};
      rows[1] = '{2'h1, 16'h00FF, 0, 2, 1'b1, 1'b1};
      rows[2] = '{2'h2, 16'hFFFE, 2, 0, 1'b0, 1'b0};
      rows[3] = '{2'h3, 16'h8001, 0, 2, 1'b0, 1'b1};
      repeat (16) @(negedge i_clk);
      i_resetn = 1;
      check_reset;
      foreach (rows[i]) begin
         run(rows[i].kind, rows[i].ea, rows[i].chg, rows[i].fol,
             rows[i].poke);
         check("mask", 16'(mask), 16'(rows[i].mask));
      end
      // reset in mid-sequence must abandon the exit cleanly
      @(negedge i_clk);
      i_start = 1;
      i_op_kind = 2'h2;
      @(negedge i_clk);
      i_start = 0;
      repeat (4) @(negedge i_clk);
      i_resetn = 0;
      @(negedge i_clk);
      i_resetn = 1;
      check_reset;
      sp_exp = 16'h0000;
      run(2'h3, 16'h4000, 0, 2, 1'b0);
      check("mask_clr", 16'(mask), 16'h0000);
      end_sim;
   end
endmodule
